// ===== logic/lpm_pkg.sv
package lpm_pkg;
    localparam logic [31:0] ADDR_STOP_CTRL = 32'h0000_0038;
    localparam logic [31:0] ADDR_CLK_CTRL  = 32'h0000_003C;
    localparam logic [31:0] ADDR_STATUS    = 32'h0000_0040;
    localparam int SMC_STOP = 7;
    localparam int SMC_RELEASE_METHOD_SELECT = 6;
    localparam int SMC_RETURN_MODE_SELECT = 5;
    localparam int SMC_KEEP = 4;
    localparam int SMC_WUT_HI = 3;
    localparam int SMC_WUT_LO = 2;
    localparam int CMC_XEN = 7;
    localparam int CMC_XTEN = 6;
    localparam int CMC_SYSCK = 5;
    localparam int CMC_IDLE = 4;
    localparam int CMC_TIMING_GEN_HALT = 2;
    localparam int CMC_TBEN = 0;
    localparam logic [7:0] SMC_RESET = 8'h00;
    localparam logic [7:0] CMC_RESET = 8'h80;
    localparam logic [7:0] SMC_RD_MASK = 8'hFC;
    localparam logic [7:0] CMC_RD_MASK = 8'hF5;
    localparam logic [17:0] WARM_FAST_0 = 18'h3_0000;
    localparam logic [17:0] WARM_FAST_1 = 18'h1_0000;
    localparam logic [17:0] WARM_FAST_2 = 18'h0_C000;
    localparam logic [17:0] WARM_FAST_3 = 18'h0_4000;
    localparam logic [17:0] WARM_SLOW_0 = 18'h0_6000;
    localparam logic [17:0] WARM_SLOW_1 = 18'h0_2000;
    localparam logic [17:0] WARM_SLOW_2 = 18'h0_00C0;
    localparam logic [17:0] WARM_SLOW_3 = 18'h0_0040;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        MODE_RUN     = 3'b000,
        MODE_GATED   = 3'b001,
        MODE_TG_HALT = 3'b010,
        MODE_STOP    = 3'b011,
        MODE_WARMUP  = 3'b100
    } mode_t;

    typedef struct packed {
        logic cpu_en;
        logic wdt_en;
        logic periph_en;
        logic tbt_en;
        logic fast_osc_en;
        logic slow_osc_en;
        logic main_slow;
        logic div_low_en;
    } clock_gates_t;

    typedef struct packed {
        logic port_hiz;
        logic stop_pin_hiz;
        logic input_force_zero;
    } port_ctrl_t;

    typedef struct packed {
        mode_t       mode;
        logic [7:0]  stop_mode_control;
        logic [7:0]  clock_mode_control;
        logic [17:0] warm_count;
        logic        tb_prev;
        logic        pin_prev;
        logic        tben_at_entry;
        logic        tb_latch;
        logic        resume;
        logic        wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] hrdata;
    } state_t;
endpackage

// ===== logic/low_power_mode_controller.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module low_power_mode_controller
#(
    parameter logic [17:0] WARM_FAST_00 = lpm_pkg::WARM_FAST_0, // fast warm-up, code 00
    parameter logic [17:0] WARM_FAST_01 = lpm_pkg::WARM_FAST_1, // fast warm-up, code 01
    parameter logic [17:0] WARM_FAST_10 = lpm_pkg::WARM_FAST_2, // fast warm-up, code 10
    parameter logic [17:0] WARM_FAST_11 = lpm_pkg::WARM_FAST_3, // fast warm-up, code 11
    parameter logic [17:0] WARM_SLOW_00 = lpm_pkg::WARM_SLOW_0, // slow warm-up, code 00
    parameter logic [17:0] WARM_SLOW_01 = lpm_pkg::WARM_SLOW_1  // slow warm-up, code 01
)
(
    input  wire logic                 clk,            // 250 MHz system clock
    input  wire logic                 nrst,           // sync reset, also reset pin
    input  wire logic                 hsel,           // ahb slave select
    input  wire logic [31:0]          haddr,          // ahb address
    input  wire logic [1:0]           htrans,         // ahb transfer type
    input  wire logic                 hwrite,         // ahb write
    input  wire logic [2:0]           hsize,          // ahb size
    input  wire logic [31:0]          hwdata,         // ahb write data
    input  wire logic                 hready,         // ahb bus ready
    output logic                      hreadyout,      // ahb slave ready
    output logic [31:0]               hrdata,         // ahb read data
    output logic                      hresp,          // ahb response
    input  wire logic                 wake_request,   // any interrupt request
    input  wire logic                 tb_source,      // selected time base clock
    input  wire logic                 stop_release_in,// stop input pin level
    input  wire logic                 fast_tick,      // one per fast osc cycle
    input  wire logic                 slow_tick,      // one per slow osc cycle
    input  wire logic                 master_interrupt_enable, // cpu master enable
    input  wire logic                 time_base_irq_enable,    // individual enable
    input  wire logic                 tb_irq_ack,     // latch cleared by cpu
    output lpm_pkg::clock_gates_t     gates,          // clock and osc enables
    output lpm_pkg::port_ctrl_t       port_ctrl,      // port state in stop
    output logic                      time_base_irq_latch, // pending time base irq
    output logic                      tb_irq_take,    // time base irq serviced
    output logic                      resume_pulse    // execution resumes
);
    import lpm_pkg::*;

    // slow warm-up codes 10 and 11 are short enough to stay fixed
    localparam logic [17:0] WARM_SLOW_10 = WARM_SLOW_2;
    localparam logic [17:0] WARM_SLOW_11 = WARM_SLOW_3;

    state_t      cur;
    state_t      next_cur;
    logic        addr_ok;
    logic        wr_now;
    logic [7:0]  wbyte;
    logic [7:0]  smc;
    logic [7:0]  cmc;
    logic        ret_slow;
    logic        tb_fall;
    logic        pin_rise;
    logic        warm_tick;
    logic [17:0] warm_target;
    logic [31:0] status_word;

    assign smc = cur.stop_mode_control;
    assign cmc = cur.clock_mode_control;
    assign ret_slow = smc[SMC_RETURN_MODE_SELECT];
    assign tb_fall = cur.tb_prev & ~tb_source;
    assign pin_rise = ~cur.pin_prev & stop_release_in;
    assign warm_tick = ret_slow ? slow_tick : fast_tick;
    assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign wr_now = cur.wr_pend;
    assign wbyte = hwdata[7:0];
    assign status_word = {26'h000_0000, cmc[CMC_SYSCK], cur.tb_latch, 1'b0, cur.mode};

    // warm-up length by code and return mode
    always_comb
    begin
        unique case (smc[SMC_WUT_HI:SMC_WUT_LO])
            2'b00:   warm_target = ret_slow ? WARM_SLOW_00 : WARM_FAST_00;
            2'b01:   warm_target = ret_slow ? WARM_SLOW_01 : WARM_FAST_01;
            2'b10:   warm_target = ret_slow ? WARM_SLOW_10 : WARM_FAST_10;
            2'b11:   warm_target = ret_slow ? WARM_SLOW_11 : WARM_FAST_11;
        endcase
    end

    always_comb
    begin
        next_cur = cur;
        next_cur.tb_prev = tb_source;
        next_cur.pin_prev = stop_release_in;
        next_cur.resume = 1'b0;
        next_cur.wr_pend = addr_ok & hwrite;
        next_cur.wr_addr = haddr;

        // registered read data for the following data phase
        if (addr_ok & ~hwrite)
        begin
            if (haddr == ADDR_STOP_CTRL)
            begin
                // low bits read back as zero
                next_cur.hrdata = {24'h00_0000, smc & SMC_RD_MASK};
            end
            else if (haddr == ADDR_CLK_CTRL)
            begin
                next_cur.hrdata = {24'h00_0000, cmc & CMC_RD_MASK};
            end
            else if (haddr == ADDR_STATUS)
            begin
                next_cur.hrdata = status_word;
            end
            else
            begin
                next_cur.hrdata = 32'h0000_0000;
            end
        end

        // register writes only take effect in run mode
        if (wr_now && cur.mode == MODE_RUN)
        begin
            if (cur.wr_addr == ADDR_STOP_CTRL)
            begin
                next_cur.stop_mode_control = wbyte;
                if (wbyte[SMC_STOP])
                begin
                    // level release with pin already high skips stop
                    if (wbyte[SMC_RELEASE_METHOD_SELECT] && stop_release_in)
                    begin
                        next_cur.mode = MODE_WARMUP;
                    end
                    else
                    begin
                        next_cur.mode = MODE_STOP;
                    end
                    next_cur.warm_count = 18'h0_0000;
                end
            end
            else if (cur.wr_addr == ADDR_CLK_CTRL)
            begin
                next_cur.clock_mode_control = wbyte;
                // idle entry also used for the slow sleeps
                if (wbyte[CMC_IDLE])
                begin
                    next_cur.mode = MODE_GATED;
                    next_cur.clock_mode_control[CMC_TIMING_GEN_HALT] = 1'b0;
                end
                else if (wbyte[CMC_TIMING_GEN_HALT])
                begin
                    next_cur.mode = MODE_TG_HALT;
                    next_cur.tben_at_entry = wbyte[CMC_TBEN];
                end
            end
        end

        unique case (cur.mode)
            MODE_RUN:
            begin
            end
            MODE_GATED:
            begin
                if (wake_request)
                begin
                    next_cur.mode = MODE_RUN;
                    next_cur.clock_mode_control[CMC_IDLE] = 1'b0;
                    next_cur.resume = 1'b1;
                end
            end
            MODE_TG_HALT:
            begin
                // falling time base edge restores clocks
                if (tb_fall)
                begin
                    next_cur.mode = MODE_RUN;
                    next_cur.clock_mode_control[CMC_TIMING_GEN_HALT] = 1'b0;
                    // slow return lands with fast osc off
                    if (cmc[CMC_SYSCK])
                    begin
                        next_cur.clock_mode_control[CMC_XEN] = 1'b0;
                    end
                    next_cur.resume = 1'b1;
                end
            end
            MODE_STOP:
            begin
                if (smc[SMC_RELEASE_METHOD_SELECT] ? stop_release_in : pin_rise)
                begin
                    next_cur.mode = MODE_WARMUP;
                    next_cur.warm_count = 18'h0_0000;
                end
            end
            MODE_WARMUP:
            begin
                if (warm_tick)
                begin
                    next_cur.warm_count = cur.warm_count + 18'h0_0001;
                end
                if (cur.warm_count >= warm_target)
                begin
                    next_cur.mode = MODE_RUN;
                    next_cur.stop_mode_control[SMC_STOP] = 1'b0;
                    // return mode selects the run flavour
                    next_cur.clock_mode_control[CMC_SYSCK] = ret_slow;
                    next_cur.clock_mode_control[CMC_XEN] = ~ret_slow;
                    next_cur.resume = 1'b1;
                end
            end
            default:
            begin
                next_cur.mode = MODE_RUN;
            end
        endcase

        // latch set on timer-wake return when TBEN was set at entry; set beats clear
        if (cur.mode == MODE_TG_HALT && tb_fall && cur.tben_at_entry)
        begin
            next_cur.tb_latch = 1'b1;
        end
        else if (tb_irq_ack)
        begin
            next_cur.tb_latch = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        // reset always lands in fast single-clock run
        if (!nrst)
        begin
            cur <= '{
                mode:               MODE_RUN,
                stop_mode_control:  SMC_RESET,
                clock_mode_control: CMC_RESET,
                warm_count:         18'h0_0000,
                tb_prev:            1'b0,
                pin_prev:           1'b0,
                tben_at_entry:      1'b0,
                tb_latch:           1'b0,
                resume:             1'b0,
                wr_pend:            1'b0,
                wr_addr:            32'h0000_0000,
                hrdata:             32'h0000_0000
            };
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // clock gating per mode
    always_comb
    begin
        gates.cpu_en = 1'b0;
        gates.wdt_en = 1'b0;
        gates.periph_en = 1'b0;
        gates.tbt_en = 1'b0;
        gates.fast_osc_en = cmc[CMC_XEN];
        gates.slow_osc_en = cmc[CMC_XTEN] | cmc[CMC_SYSCK];
        gates.main_slow = cmc[CMC_SYSCK];
        // first divider stage stopped in slow with fast osc off
        gates.div_low_en = ~(cmc[CMC_SYSCK] & ~cmc[CMC_XEN]);
        unique case (cur.mode)
            MODE_RUN:
            begin
                gates.cpu_en = 1'b1;
                gates.wdt_en = 1'b1;
                gates.periph_en = 1'b1;
                gates.tbt_en = 1'b1;
            end
            MODE_GATED:
            begin
                // cpu and watchdog halted, peripherals clocked
                // fast osc follows its enable bit in sleep
                gates.periph_en = 1'b1;
                gates.tbt_en = 1'b1;
            end
            MODE_TG_HALT:
            begin
                // only the time base keeps its clock
                gates.tbt_en = 1'b1;
            end
            MODE_STOP:
            begin
                gates.fast_osc_en = 1'b0;
                gates.slow_osc_en = 1'b0;
                gates.div_low_en = 1'b0;
            end
            MODE_WARMUP:
            begin
                gates.fast_osc_en = ~ret_slow;
                gates.slow_osc_en = ret_slow | cmc[CMC_XTEN];
                gates.main_slow = ret_slow;
                gates.div_low_en = ~ret_slow;
            end
            default:
            begin
            end
        endcase
    end

    assign port_ctrl.port_hiz = (cur.mode == MODE_STOP) & ~smc[SMC_KEEP];
    assign port_ctrl.stop_pin_hiz = (cur.mode == MODE_STOP);
    // inputs forced low with outputs off
    assign port_ctrl.input_force_zero = (cur.mode == MODE_STOP) & ~smc[SMC_KEEP];

    // service only with all three enables
    assign tb_irq_take = cur.tb_latch & master_interrupt_enable & time_base_irq_enable
                         & cmc[CMC_TBEN] & (cur.mode == MODE_RUN);

    assign time_base_irq_latch = cur.tb_latch;
    assign resume_pulse = cur.resume;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = cur.hrdata;
endmodule

// ===== sim/lpm_sva.sv
`timescale 1ns/100ps
module lpm_sva
(
    input wire logic                  clk,                     // clock
    input wire logic                  nrst,                    // sync reset
    input wire logic                  wake_request,            // wake level
    input wire logic                  tb_source,               // time base clock
    input wire logic                  master_interrupt_enable, // master enable
    input wire logic                  time_base_irq_enable,    // irq enable
    input wire lpm_pkg::clock_gates_t gates,                   // clock enables
    input wire lpm_pkg::port_ctrl_t   port_ctrl,               // port state
    input wire logic                  time_base_irq_latch,     // pending latch
    input wire logic                  tb_irq_take,             // irq serviced
    input wire logic                  resume_pulse             // resume
);
    import lpm_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_tg_fall;
        !gates.cpu_en && !gates.periph_en && gates.tbt_en && $fell(tb_source);
    endsequence
    sequence s_run_back;
        gates.cpu_en && gates.periph_en;
    endsequence
    sleep_slow_a: assert property (
        !gates.cpu_en && gates.periph_en && gates.main_slow |-> !gates.wdt_en && gates.slow_osc_en)
        else $error("slow sleep clocks wrong");
    div_stop_a: assert property (
        (gates.cpu_en || gates.periph_en) && gates.main_slow && !gates.fast_osc_en
        |-> !gates.div_low_en) else $error("divider runs with fast osc off");
    sleep_wake_a: assert property (
        !gates.cpu_en && gates.periph_en && wake_request |=> gates.cpu_en ##[0:1] resume_pulse)
        else $error("sleep not left on wake");
    tg_exit_a: assert property (
        s_tg_fall |-> ##[1:2] s_run_back) else $error("timer wake not left on fall");
    tg_slow_a: assert property (
        s_tg_fall ##0 gates.main_slow |-> ##[1:2] gates.cpu_en && !gates.fast_osc_en)
        else $error("timer wake return mode wrong");
    irq_take_a: assert property (
        tb_irq_take |-> time_base_irq_latch && master_interrupt_enable && time_base_irq_enable
        && gates.cpu_en) else $error("time base irq taken without enables");
    stop_halt_a: assert property (
        port_ctrl.stop_pin_hiz |-> !gates.fast_osc_en && !gates.slow_osc_en && !gates.cpu_en
        && !gates.periph_en && !gates.tbt_en) else $error("stop not halting clocks");
    pin_hiz_a: assert property (
        port_ctrl.port_hiz || port_ctrl.input_force_zero |-> port_ctrl.stop_pin_hiz
        && (port_ctrl.port_hiz == port_ctrl.input_force_zero)) else $error("stop port state wrong");
    resume_once_a: assert property (
        resume_pulse |-> s_run_back ##1 !resume_pulse) else $error("resume pulse wrong");
endmodule
bind low_power_mode_controller lpm_sva lpm_sva_inst
(
    .clk, .nrst, .wake_request, .tb_source, .master_interrupt_enable, .time_base_irq_enable,
    .gates, .port_ctrl, .time_base_irq_latch, .tb_irq_take, .resume_pulse
);

// ===== sim/lpm_partner.sv
`timescale 1ns/100ps
module lpm_partner
(
    input  wire logic clk,             // system clock
    input  wire logic nrst,            // sync reset
    input  wire logic pin_level,       // requested stop pin level
    output logic      stop_release_in, // stop pin
    output logic      fast_tick,       // fast osc cycle
    output logic      slow_tick,       // slow osc cycle
    output logic      tb_source        // time base source clock
);
    logic [5:0] div;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            div <= 6'h00;
            stop_release_in <= 1'b0;
        end
        else
        begin
            div <= div + 6'h01;
            stop_release_in <= pin_level;
        end
    end
    assign fast_tick = div[0];
    assign slow_tick = (div[2:0] == 3'h7);
    assign tb_source = div[5];
endmodule

// ===== sim/tb_low_power_mode_controller.sv
`timescale 1ns/100ps
module tb_low_power_mode_controller;
    import lpm_pkg::*;
    logic         clk, nrst, hsel, hwrite, hreadyout, hresp, wake_request, pin_level;
    logic         tb_source, stop_release_in, fast_tick, slow_tick, tb_irq_ack;
    logic         master_interrupt_enable, time_base_irq_enable, time_base_irq_latch;
    logic         tb_irq_take, resume_pulse;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    clock_gates_t gates;
    port_ctrl_t   port_ctrl;
    int           num_errors, cmp_count;

    low_power_mode_controller #(.WARM_FAST_00(18'h0_0004), .WARM_FAST_01(18'h0_0004),
        .WARM_FAST_10(18'h0_0004), .WARM_FAST_11(18'h0_0004), .WARM_SLOW_00(18'h0_0004))
        low_power_mode_controller_inst
    (
        .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .wake_request, .tb_source, .stop_release_in, .fast_tick,
        .slow_tick, .master_interrupt_enable, .time_base_irq_enable, .tb_irq_ack, .gates,
        .port_ctrl, .time_base_irq_latch, .tb_irq_take, .resume_pulse
    );
    lpm_partner lpm_partner_inst
    (
        .clk, .nrst, .pin_level, .stop_release_in, .fast_tick, .slow_tick, .tb_source
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // address phase held until ready, then data phase held until ready
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= addr;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        check(n, rd, e);
    endtask

    task automatic to_fast;
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00E0);
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00C0);
    endtask

    task automatic wait_resume(input logic slow, output int ticks);
        int n;
        ticks = 0;
        n = 0;
        while (resume_pulse !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            #1;
            n++;
            if ((slow ? slow_tick : fast_tick) === 1'b1)
                ticks++;
        end
    endtask

    task automatic t_reset;
        @(posedge clk);
        #1;
        check("reset gates", 32'(gates), 32'h0000_00F9);
        rdc(ADDR_STOP_CTRL, 32'(SMC_RESET), "stop ctrl reset");
        rdc(ADDR_CLK_CTRL, 32'(CMC_RESET), "clk ctrl reset");
        bus(1'b1, ADDR_STOP_CTRL, 32'h0000_005F);
        rdc(ADDR_STOP_CTRL, 32'h0000_005C, "low bits");
        bus(1'b1, 32'h0000_0044, 32'h0000_00FF);
        rdc(32'h0000_0044, 32'h0, "unmapped");
        bus(1'b1, ADDR_STOP_CTRL, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_sleep(input logic xen);
        int n;
        logic [31:0] c;
        c = {24'h0, xen, 7'h60};
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00C0);
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00E0);
        bus(1'b1, ADDR_CLK_CTRL, c);
        bus(1'b1, ADDR_CLK_CTRL, c | 32'h0000_0010);
        repeat (3) @(posedge clk);
        #1;
        check("sleep gates", 32'(gates), {24'h0, 4'h3, xen, 2'b11, xen});
        @(posedge clk);
        wake_request <= 1'b1;
        wait_resume(1'b0, n);
        @(posedge clk);
        wake_request <= 1'b0;
        check("wake gates", 32'(gates), {24'h0, 4'hF, xen, 2'b11, xen});
        rdc(ADDR_CLK_CTRL, c, "idle bit");
        to_fast();
        $display("test slow sleep done");
    endtask

    task automatic t_tgw(input logic tben);
        int n;
        to_fast();
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00E0);
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_0060);
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_0064 | 32'(tben));
        repeat (2) @(posedge clk);
        #1;
        check("halt gates", 32'(gates), 32'h0000_0016);
        wait_resume(1'b0, n);
        @(posedge clk);
        #1;
        check("halt exit", 32'(gates), 32'h0000_00F6);
        check("tb latch", 32'(time_base_irq_latch), 32'(tben));
        master_interrupt_enable <= 1'b1;
        time_base_irq_enable <= 1'b1;
        @(posedge clk);
        #1;
        check("irq take", 32'(tb_irq_take), 32'(tben));
        master_interrupt_enable <= 1'b0;
        @(posedge clk);
        #1;
        check("irq masked", 32'(tb_irq_take), 32'h0);
        tb_irq_ack <= 1'b1;
        @(posedge clk);
        tb_irq_ack <= 1'b0;
        rdc(ADDR_CLK_CTRL, 32'h0000_0060 | 32'(tben), "halt bit");
        to_fast();
        $display("test timer wake done");
    endtask

    task automatic t_stop(input logic release_method_select, return_mode_select, keep, input logic [1:0] warmup_time_select);
        int n, t;
        logic [31:0] s;
        s = {24'h0, 1'b1, release_method_select, return_mode_select, keep, warmup_time_select, 2'b00};
        t = (return_mode_select && warmup_time_select == 2'd2) ? 192 : ((return_mode_select && warmup_time_select == 2'd3) ? 64 : 4);
        if (return_mode_select)
        begin
            bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00E0);
            bus(1'b1, ADDR_CLK_CTRL, 32'h0000_0060);
        end
        pin_level <= !release_method_select;
        bus(1'b1, ADDR_STOP_CTRL, s);
        repeat (8) @(posedge clk);
        #1;
        check("stop ports", 32'(port_ctrl), {29'h0, !keep, 1'b1, !keep});
        check("stop clocks", 32'(gates & 8'hFC), 32'h0);
        pin_level <= 1'b0;
        repeat (4) @(posedge clk);
        pin_level <= 1'b1;
        wait_resume(return_mode_select, n);
        check("warm-up", 32'(n >= t && n <= t + 3), 32'h1);
        check("return", 32'({gates.cpu_en, gates.main_slow, gates.fast_osc_en}),
              32'({1'b1, return_mode_select, !return_mode_select}));
        pin_level <= 1'b0;
        rdc(ADDR_STOP_CTRL, s & 32'h0000_007F, "stop bit");
        to_fast();
        $display("test stop done");
    endtask

    task automatic t_rst_stop;
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_00E0);
        bus(1'b1, ADDR_CLK_CTRL, 32'h0000_0060);
        bus(1'b1, ADDR_STOP_CTRL, 32'h0000_00A0);
        repeat (4) @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check("reset exit", 32'(gates), 32'h0000_00F9);
        rdc(ADDR_CLK_CTRL, 32'(CMC_RESET), "reset mode");
        $display("test reset in stop done");
    endtask

    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wake_request = 1'b0;
        pin_level = 1'b0;
        master_interrupt_enable = 1'b0;
        time_base_irq_enable = 1'b0;
        tb_irq_ack = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_tgw(1'b0);
        t_tgw(1'b1);
        t_stop(1'b0, 1'b0, 1'b0, 2'd0);
        t_stop(1'b1, 1'b0, 1'b1, 2'd1);
        t_stop(1'b0, 1'b1, 1'b0, 2'd2);
        t_stop(1'b1, 1'b1, 1'b1, 2'd3);
        t_rst_stop();
        final_report();
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        final_report();
    end
endmodule
